// [rtl/blp_top.sv]
// How it works
// R1: The backlash amount is a signed value clamped to -1000..1000, zero at reset, sign picks direction and size is magnitude; the code does not reset it.
// R2: A positive amount compensates forward moves.
// R3: A negative amount compensates reverse moves.
// R4: The amount is latched at each move start, so a change acts from the next move only.
// R5: With an incremental encoder the last homing direction is the reference and the other direction is compensated.
// R6: With an absolute encoder the first move direction is the reference and the other direction is compensated.
// R7: Monitor outputs carry the logical target and the logical position only, never the offset.
// R8: The offset is added only to the motor position command, never to the logical coordinate.
// R9: Torque is limited from the internal setting only; there is no external limit input.
// R10: The configurer keeps the external encoder pitch at or below the ceiling for the scale type; a flag reports a breach.
// R11: The offset is inserted once per reversal into the compensated direction and removed on reversal back.
`timescale 1ns/1ps
`default_nettype none
module blp_top #(
  parameter int POS_W = blp_pkg::POS_W
) (
  // Clock and reset
  input  wire logic                    I_CLOCK,
  input  wire logic                    I_RESET_N,
  // Settings
  input  wire logic signed [10:0]      I_BACKLASH_AMOUNT,
  input  wire logic                    I_ABS_ENCODER,
  input  wire logic [15:0]             I_INTERNAL_TORQUE_LIMIT,
  input  wire logic [31:0]             I_EXTERNAL_ENCODER_PITCH,
  input  wire logic [7:0]              I_SCALE_TYPE_RESPONSE,
  // Move profile from the positioning engine
  input  wire logic                    I_MOVE_START,
  input  wire logic signed [POS_W-1:0] I_TARGET,
  input  wire logic signed [POS_W-1:0] I_LOGICAL_POS,
  input  wire logic                    I_HOME_DONE,
  input  wire logic                    I_HOME_LAST_FWD,
  // Toward the drive and monitors
  output logic signed [POS_W-1:0]      O_MOTOR_POS_CMD,
  output logic signed [POS_W-1:0]      O_TARGET_MONITOR,
  output logic signed [POS_W-1:0]      O_POS_MONITOR,
  output logic [15:0]                  O_TORQUE_LIMIT,
  output logic                         O_PITCH_WARNING
);
  // ****************************************
  // Move start capture
  // ****************************************
  blp_move_if mv ();
  logic signed [10:0]      amount_clamped;
  logic signed [POS_W-1:0] last_target;
  logic [31:0]             pitch_max;

  always_comb begin
    if (I_BACKLASH_AMOUNT > blp_pkg::BL_MAX) begin
      amount_clamped = blp_pkg::BL_MAX; // R1
    end else if (I_BACKLASH_AMOUNT < blp_pkg::BL_MIN) begin
      amount_clamped = blp_pkg::BL_MIN; // R1
    end else begin
      amount_clamped = I_BACKLASH_AMOUNT;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      last_target <= '0;
    end else if (I_MOVE_START || I_HOME_DONE) begin
      last_target <= I_MOVE_START ? I_TARGET : I_LOGICAL_POS;
    end
  end

  // Amount sampled only at move start; mid-move edits wait
  assign mv.start  = I_MOVE_START; // R4
  assign mv.amount = amount_clamped; // R4
  assign mv.fwd    = (I_TARGET > last_target);

  blp_offset u_offset (
    .i_clock         (I_CLOCK),
    .i_reset_n       (I_RESET_N),
    .i_home_done     (I_HOME_DONE),
    .i_abs_enc       (I_ABS_ENCODER),
    .i_last_home_fwd (I_HOME_LAST_FWD),
    .mv              (mv)
  );

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_MOTOR_POS_CMD  <= '0;
      O_TARGET_MONITOR <= '0;
      O_POS_MONITOR    <= '0;
    end else begin
      O_MOTOR_POS_CMD  <= I_LOGICAL_POS + POS_W'(mv.offset); // R8
      O_TARGET_MONITOR <= last_target; // R7
      O_POS_MONITOR    <= I_LOGICAL_POS; // R7
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TORQUE_LIMIT <= '0;
    end else begin
      O_TORQUE_LIMIT <= I_INTERNAL_TORQUE_LIMIT; // R9
    end
  end

  always_comb begin
    case (I_SCALE_TYPE_RESPONSE)
      blp_pkg::SCALE_8BIT:  pitch_max = blp_pkg::PITCH_MAX_8;
      blp_pkg::SCALE_9BIT:  pitch_max = blp_pkg::PITCH_MAX_9;
      blp_pkg::SCALE_10BIT: pitch_max = blp_pkg::PITCH_MAX_10;
      blp_pkg::SCALE_13BIT: pitch_max = blp_pkg::PITCH_MAX_13;
      default:              pitch_max = '1;
    endcase
  end

  // Warning only: clamping the pitch would hide a misconfiguration
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PITCH_WARNING <= 1'b0;
    end else begin
      O_PITCH_WARNING <= (I_EXTERNAL_ENCODER_PITCH > pitch_max); // R10
    end
  end
endmodule
`default_nettype wire

// [rtl/blp_pkg.sv]
package blp_pkg;
  // Position words in reference units
  localparam int POS_W = 32;
  localparam int BL_W = 11;
  localparam logic signed [10:0] BL_MAX = 11'sd1000;
  localparam logic signed [10:0] BL_MIN = -11'sd1000;
  localparam logic signed [10:0] BL_RESET = 11'sd0;
  // Encoder kinds
  localparam logic ENC_INCREMENTAL = 1'b0;
  localparam logic ENC_ABSOLUTE = 1'b1;
  // Pitch ceilings per scale resolution
  localparam logic [7:0] SCALE_8BIT = 8'h08;
  localparam logic [7:0] SCALE_9BIT = 8'h09;
  localparam logic [7:0] SCALE_10BIT = 8'h0A;
  localparam logic [7:0] SCALE_13BIT = 8'h0D;
  localparam logic [31:0] PITCH_MAX_8 = 32'd65103;
  localparam logic [31:0] PITCH_MAX_9 = 32'd32551;
  localparam logic [31:0] PITCH_MAX_10 = 32'd16;
  localparam logic [31:0] PITCH_MAX_13 = 32'd2034;
  typedef enum logic [1:0] {
    BLP_REF_NONE = 2'b00,
    BLP_REF_FWD  = 2'b01,
    BLP_REF_REV  = 2'b10
  } blp_ref_type;
endpackage

// [rtl/blp_move_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface blp_move_if;
  logic                        start;
  logic                        fwd;
  logic signed [10:0]          amount;
  logic signed [31:0]          offset;
  modport ctrl (output start, output fwd, output amount, input offset);
  modport comp (input start, input fwd, input amount, output offset);
endinterface
`default_nettype wire

// [rtl/blp_offset.sv]
`timescale 1ns/1ps
`default_nettype none
module blp_offset (
  input  wire logic  i_clock,
  input  wire logic  i_reset_n,
  input  wire logic  i_home_done,
  input  wire logic  i_abs_enc,
  input  wire logic  i_last_home_fwd,
  blp_move_if.comp   mv
);
  blp_pkg::blp_ref_type ref_dir;
  logic                 applied;
  logic signed [10:0]   mag;
  logic                 comp_fwd;

  // Reference direction: homing end (incremental) or first move (absolute)
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_dir <= blp_pkg::BLP_REF_NONE;
    end else if (i_home_done && i_abs_enc == blp_pkg::ENC_INCREMENTAL) begin
      ref_dir <= i_last_home_fwd ? blp_pkg::BLP_REF_FWD
                                 : blp_pkg::BLP_REF_REV; // R5
    end else if (mv.start && ref_dir == blp_pkg::BLP_REF_NONE
                 && i_abs_enc == blp_pkg::ENC_ABSOLUTE) begin
      ref_dir <= mv.fwd ? blp_pkg::BLP_REF_FWD
                        : blp_pkg::BLP_REF_REV; // R6
    end
  end

  assign mag = (mv.amount < 0) ? -mv.amount : mv.amount;
  assign comp_fwd = (mv.amount > 0); // R2 R3

  // Insert once on reversal into the compensated side, remove on return
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      applied    <= 1'b0;
      mv.offset  <= '0;
    end else if (i_home_done) begin
      applied    <= 1'b0;
      mv.offset  <= '0;
    end else if (mv.start && ref_dir != blp_pkg::BLP_REF_NONE) begin
      if (mv.amount != 0 && mv.fwd == comp_fwd
          && (ref_dir == blp_pkg::BLP_REF_FWD) != mv.fwd) begin
        applied   <= 1'b1; // R11
        mv.offset <= comp_fwd ? 32'(mag) : -32'(mag); // R2 R3
      end else begin
        applied   <= 1'b0; // R11
        mv.offset <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/blp_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
module blp_drive_model (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_reset_n,
  // Command in, encoder position out
  input  wire logic signed [31:0] i_cmd,
  output logic signed [31:0]      o_act
);
  // Loop follows the command one cycle late
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) o_act <= '0;
    else o_act <= i_cmd;
  end
endmodule
`default_nettype wire

// [bench/blp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module blp_properties #(
  parameter int POS_W = 32
) (
  // Clock, reset, settings and move profile
  input wire logic                    I_CLOCK,
  input wire logic                    I_RESET_N,
  input wire logic                    I_ABS_ENCODER,
  input wire logic [15:0]             I_INTERNAL_TORQUE_LIMIT,
  input wire logic [31:0]             I_EXTERNAL_ENCODER_PITCH,
  input wire logic [7:0]              I_SCALE_TYPE_RESPONSE,
  input wire logic                    I_MOVE_START,
  input wire logic signed [POS_W-1:0] I_TARGET,
  input wire logic signed [POS_W-1:0] I_LOGICAL_POS,
  input wire logic                    I_HOME_DONE,
  // Outputs
  input wire logic signed [POS_W-1:0] O_MOTOR_POS_CMD,
  input wire logic signed [POS_W-1:0] O_TARGET_MONITOR,
  input wire logic signed [POS_W-1:0] O_POS_MONITOR,
  input wire logic [15:0]             O_TORQUE_LIMIT,
  input wire logic                    O_PITCH_WARNING
);
  logic signed [POS_W-1:0] d;
  logic                    homed;
  logic                    moved;
  logic [31:0]             ceil;
  assign d = O_MOTOR_POS_CMD - O_POS_MONITOR;
  // Pitch ceiling of the reported scale; unknown scales never warn
  always_comb begin
    case (I_SCALE_TYPE_RESPONSE)
      blp_pkg::SCALE_8BIT:  ceil = blp_pkg::PITCH_MAX_8;
      blp_pkg::SCALE_9BIT:  ceil = blp_pkg::PITCH_MAX_9;
      blp_pkg::SCALE_10BIT: ceil = blp_pkg::PITCH_MAX_10;
      blp_pkg::SCALE_13BIT: ceil = blp_pkg::PITCH_MAX_13;
      default:              ceil = '1;
    endcase
  end
  // Reference state, so refused moves can be told apart
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) {homed, moved} <= 2'h0;
    else {homed, moved} <= {homed | I_HOME_DONE, moved | I_MOVE_START};
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_zero; ##2 d == '0; endsequence
  property p_range; d <= blp_pkg::BL_MAX && d >= blp_pkg::BL_MIN; endproperty
  property p_hold; !I_MOVE_START && !I_HOME_DONE |-> ##2 $stable(d); endproperty
  property p_pos; I_RESET_N |=> O_POS_MONITOR == $past(I_LOGICAL_POS); endproperty
  property p_trq;
    I_RESET_N |=> O_TORQUE_LIMIT == $past(I_INTERNAL_TORQUE_LIMIT);
  endproperty
  // Target is latched first, then copied to the monitor: two edges
  property p_tgt;
    I_MOVE_START |-> ##2 O_TARGET_MONITOR == $past(I_TARGET, 2);
  endproperty
  property p_pitch;
    I_RESET_N |=> O_PITCH_WARNING == $past(I_EXTERNAL_ENCODER_PITCH > ceil);
  endproperty
  property p_home; I_HOME_DONE |-> s_zero; endproperty
  property p_inc; I_MOVE_START && !I_ABS_ENCODER && !homed |-> s_zero; endproperty
  property p_abs; I_MOVE_START && I_ABS_ENCODER && !moved |-> s_zero; endproperty
  a_range: assert property (p_range) else $error("offset too big");
  a_hold: assert property (p_hold) else $error("offset moved");
  a_pos: assert property (p_pos) else $error("pos monitor wrong");
  a_trq: assert property (p_trq) else $error("torque limit wrong");
  a_tgt: assert property (p_tgt) else $error("target monitor wrong");
  a_pitch: assert property (p_pitch) else $error("pitch flag wrong");
  a_home: assert property (p_home) else $error("home kept offset");
  a_inc: assert property (p_inc) else $error("unhomed offset");
  a_abs: assert property (p_abs) else $error("first move offset");
endmodule
bind blp_top blp_properties #(.POS_W(POS_W)) u_props (.I_CLOCK, .I_RESET_N,
  .I_ABS_ENCODER, .I_INTERNAL_TORQUE_LIMIT, .I_EXTERNAL_ENCODER_PITCH,
  .I_SCALE_TYPE_RESPONSE, .I_MOVE_START, .I_TARGET, .I_LOGICAL_POS,
  .I_HOME_DONE, .O_MOTOR_POS_CMD, .O_TARGET_MONITOR, .O_POS_MONITOR,
  .O_TORQUE_LIMIT, .O_PITCH_WARNING);
`default_nettype wire

// [bench/backlash_compensation_positioner_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module backlash_compensation_positioner_tb;
  logic I_CLOCK = 0, I_RESET_N = 0, I_ABS_ENCODER = 0, I_MOVE_START = 0;
  logic I_HOME_DONE = 0, I_HOME_LAST_FWD = 0, O_PITCH_WARNING;
  logic signed [10:0] I_BACKLASH_AMOUNT = '0;
  logic [15:0] I_INTERNAL_TORQUE_LIMIT = '0, O_TORQUE_LIMIT;
  logic [31:0] I_EXTERNAL_ENCODER_PITCH = '0;
  logic [7:0] I_SCALE_TYPE_RESPONSE = 8'h09;
  logic signed [31:0] I_TARGET = '0, I_LOGICAL_POS = '0, O_MOTOR_POS_CMD, act;
  logic signed [31:0] O_TARGET_MONITOR, O_POS_MONITOR, q[$];
  logic [1:0] sp = '0;
  int bad_count = 0, check_count = 0, seed = 32'hb417, k;
  logic [7:0] sc [4] = '{blp_pkg::SCALE_8BIT, blp_pkg::SCALE_9BIT,
    blp_pkg::SCALE_10BIT, blp_pkg::SCALE_13BIT};
  logic [31:0] pm [4] = '{blp_pkg::PITCH_MAX_8, blp_pkg::PITCH_MAX_9,
    blp_pkg::PITCH_MAX_10, blp_pkg::PITCH_MAX_13};
  always #10 I_CLOCK = ~I_CLOCK;
  blp_top uut (.I_CLOCK, .I_RESET_N, .I_BACKLASH_AMOUNT, .I_ABS_ENCODER,
    .I_INTERNAL_TORQUE_LIMIT, .I_EXTERNAL_ENCODER_PITCH, .I_SCALE_TYPE_RESPONSE,
    .I_MOVE_START, .I_TARGET, .I_LOGICAL_POS, .I_HOME_DONE, .I_HOME_LAST_FWD,
    .O_MOTOR_POS_CMD, .O_TARGET_MONITOR, .O_POS_MONITOR, .O_TORQUE_LIMIT,
    .O_PITCH_WARNING);
  blp_drive_model drv (.i_clock(I_CLOCK), .i_reset_n(I_RESET_N),
    .i_cmd(O_MOTOR_POS_CMD), .o_act(act));
  // Small logical positions keep every test target's direction unambiguous
  always @(posedge I_CLOCK) begin
    I_LOGICAL_POS <= $random(seed) & 32'h0000_00FF;
    I_INTERNAL_TORQUE_LIMIT <= 16'($random(seed));
    // Every known scale, pitch at or just over its ceiling
    k = $random(seed) & 3;
    I_SCALE_TYPE_RESPONSE <= sc[k];
    I_EXTERNAL_ENCODER_PITCH <= pm[k] + ($random(seed) & 1);
    sp <= {sp[0], I_MOVE_START};
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask
  always @(negedge I_CLOCK) if (sp[1] && q.size() > 0) begin
    chk("offset", q.pop_front(), O_MOTOR_POS_CMD - O_POS_MONITOR);
    chk("target", I_TARGET, O_TARGET_MONITOR);
  end
  task summarize;
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task mv(input logic signed [31:0] t, input logic signed [31:0] e);
    @(posedge I_CLOCK);
    I_MOVE_START <= 1'b1;
    I_TARGET <= t;
    q.push_back(e);
    @(posedge I_CLOCK);
    I_MOVE_START <= 1'b0;
    repeat (3) @(posedge I_CLOCK);
  endtask
  task hm(input logic f);
    @(posedge I_CLOCK);
    I_HOME_DONE <= 1'b1;
    I_HOME_LAST_FWD <= f;
    @(posedge I_CLOCK);
    I_HOME_DONE <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge I_CLOCK);
    I_RESET_N <= 1'b1;
    I_BACKLASH_AMOUNT <= 11'h12C;
    mv(32'h0000_03E8, '0);
    hm(1'b0);
    mv(32'h0000_07D0, 32'h0000_012C);
    mv(32'h0000_0BB8, 32'h0000_012C);
    I_BACKLASH_AMOUNT <= 11'h1F4;
    mv(32'h0000_03E8, '0);
    mv(32'h0000_0FA0, 32'h0000_01F4);
    I_BACKLASH_AMOUNT <= 11'h738;
    hm(1'b1);
    mv(32'hFFFF_EC78, 32'hFFFF_FF38);
    I_RESET_N <= 1'b0;
    I_ABS_ENCODER <= 1'b1;
    I_BACKLASH_AMOUNT <= 11'h3FF;
    repeat (3) @(posedge I_CLOCK);
    I_RESET_N <= 1'b1;
    mv(32'hFFFF_EC78, '0);
    mv(32'h0000_03E8, 32'h0000_03E8);
    summarize;
  end
  initial begin
    repeat (1000) @(posedge I_CLOCK);
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
